// File: hw/scwt_consts.svh
// offsets, field positions, reset values for the smart-card wait parameters
`ifndef SCWT_CONSTS_SVH
`define SCWT_CONSTS_SVH

// register indexes; byte address is four times the index
`define SCWT_IDX_CTRL       6'h30
`define SCWT_IDX_STATUS     6'h31
`define SCWT_IDX_ATR_HIGH   6'h3A
`define SCWT_IDX_ATR_LOW    6'h3B
`define SCWT_IDX_WAIT_HIGH  6'h3C
`define SCWT_IDX_WAIT_LOW   6'h3D
`define SCWT_IDX_WAIT_GUARD 6'h3E
`define SCWT_IDX_CHAR_WAIT2 6'h3F

// control fields
`define SCWT_CTRL_ENABLE_BIT 0
`define SCWT_CTRL_TYPE_BIT   1

// status fields
`define SCWT_STAT_RUN_BIT    0
`define SCWT_STAT_EXP_BIT    1

// field positions of the wait-and-guard and second wait registers
`define SCWT_CHAR_WAIT_FIRST_PART_MSB 7
`define SCWT_CHAR_WAIT_FIRST_PART_LSB 4
`define SCWT_BGI_MSB  3
`define SCWT_BGI_LSB  0
`define SCWT_CHAR_WAIT_SECOND_PART_MSB 4
`define SCWT_CHAR_WAIT_SECOND_PART_LSB 0

// reset values
`define SCWT_RST_BYTE      8'h00
`define SCWT_RST_WAIT_LOW  8'h38
`define SCWT_RST_COUNT     16'h0000
`define SCWT_ZERO_WORD     32'h0000_0000

`endif

// File: hw/scwt_pkg.sv
// types shared by the smart-card wait parameter bank
package scwt_pkg;
   typedef logic [7:0]  scwt_byte_type;
   typedef logic [15:0] scwt_word16_type;
   typedef logic [5:0]  scwt_index_type;
   typedef enum logic {
      SCWT_T0,
      SCWT_T1
   } scwt_proto_type;
   typedef enum logic [1:0] {
      SCWT_IDLE,
      SCWT_COUNT,
      SCWT_EXPIRED
   } scwt_atr_state_type;
endpackage : scwt_pkg

// File: hw/scwt_apb_ctl.sv
// apb handshake: no wait state, ready is up in the first access cycle
`timescale 1ns/1ns
module scwt_apb_ctl (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic psel,
   input  wire logic penable,
   input  wire logic pwrite,
   output logic      pready,
   output logic      wr_strobe,
   output logic      setup_cycle
);
   import scwt_pkg::*;

   // ******************************
   // handshake
   // ******************************
   assign setup_cycle = psel & ~penable;
   assign wr_strobe   = psel & penable & pready & pwrite;

   // ready raised at the setup edge so the access lasts exactly one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup_cycle;
      end
   end
endmodule : scwt_apb_ctl

// File: hw/scwt_atr_counter.sv
// answer-to-reset duration counter
`timescale 1ns/1ns
`include "scwt_consts.svh"
module scwt_atr_counter (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      enable,
   input  wire scwt_pkg::scwt_proto_type  proto,
   input  wire scwt_pkg::scwt_word16_type duration,
   input  wire logic                      clear,
   input  wire logic                      ts_detected,
   input  wire logic                      etu_tick,
   output logic                           running,
   output logic                           expired
);
   import scwt_pkg::*;

   scwt_atr_state_type state_reg;
   scwt_word16_type    count_reg;
   logic               armed;

   // zero duration or t=1 leaves the counter off
   assign armed = enable && (proto == SCWT_T0)
                  && (duration != `SCWT_RST_COUNT);

   // ******************************
   // counter state
   // ******************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= SCWT_IDLE;
         count_reg <= `SCWT_RST_COUNT;
      end else if (clear || !armed) begin
         state_reg <= SCWT_IDLE;
         count_reg <= `SCWT_RST_COUNT;
      end else begin
         case (state_reg)
            SCWT_IDLE: begin
               // start only after the full ts character has been seen
               if (ts_detected) begin
                  state_reg <= SCWT_COUNT;
                  count_reg <= duration;
               end
            end
            SCWT_COUNT: begin
               if (etu_tick) begin
                  if (count_reg == 16'h0001) begin
                     state_reg <= SCWT_EXPIRED;
                  end
                  count_reg <= count_reg - 16'h0001;
               end
            end
            default: begin
               state_reg <= SCWT_EXPIRED;
            end
         endcase
      end
   end

   assign running = (state_reg == SCWT_COUNT);
   assign expired = (state_reg == SCWT_EXPIRED);
endmodule : scwt_atr_counter

// File: hw/scwt_params.sv
// smart-card wait and guard parameter bank behind apb
`timescale 1ns/1ns
`include "scwt_consts.svh"
module scwt_params (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   input  wire logic [3:0]                pstrb,
   input  wire logic                      ts_detected,
   input  wire logic                      etu_tick,
   output logic [31:0]                    prdata,
   output logic                           pready,
   output logic                           pslverr,
   output logic                           smartcard_mode_enable,
   output scwt_pkg::scwt_proto_type       protocol_type_select,
   output scwt_pkg::scwt_word16_type      answer_duration_integer,
   output scwt_pkg::scwt_word16_type      char_wait_integer,
   output scwt_pkg::scwt_word16_type      block_wait_integer,
   output logic [3:0]                     char_wait_first_part,
   output logic [4:0]                     char_wait_second_part,
   output logic [3:0]                     block_guard_integer,
   output logic                           answer_duration_running,
   output logic                           answer_duration_expired
);
   import scwt_pkg::*;

   // ******************************
   // storage
   // ******************************
   logic           enable_reg;
   scwt_proto_type type_reg;
   scwt_byte_type  atr_high_reg;
   scwt_byte_type  atr_low_reg;
   // both banks are kept, so a type switch does not lose the other set
   scwt_byte_type  wait_high_t0_reg;
   scwt_byte_type  wait_low_t0_reg;
   scwt_byte_type  bwait_high_t1_reg;
   scwt_byte_type  bwait_low_t1_reg;
   scwt_byte_type  wait_guard_reg;
   logic [4:0]     char_wait2_reg;
   logic           run_reg;
   logic           exp_reg;
   logic [31:0]    prdata_next;
   logic           err_next;

   // ******************************
   // bus decode
   // ******************************
   logic           wr_strobe;
   logic           setup_cycle;
   logic           wr_lane;
   logic           param_wr;
   logic           atr_zero_wr;
   logic           counter_clear;
   logic           counter_running;
   logic           counter_expired;
   scwt_index_type index;
   scwt_byte_type  wbyte;

   scwt_apb_ctl u_apb (
      .pclk        (pclk),
      .presetn     (presetn),
      .psel        (psel),
      .penable     (penable),
      .pwrite      (pwrite),
      .pready      (pready),
      .wr_strobe   (wr_strobe),
      .setup_cycle (setup_cycle)
   );

   function automatic logic hit(input logic [7:0] addr,
                                input scwt_index_type idx);
      hit = (addr[1:0] == 2'b00) && (addr[7:2] == idx);
   endfunction : hit

   function automatic scwt_word16_type join16(input scwt_byte_type hi,
                                              input scwt_byte_type lo);
      join16 = {hi, lo};
   endfunction : join16

   assign index   = paddr[7:2];
   assign wbyte   = pwdata[7:0];
   assign wr_lane = wr_strobe & pstrb[0];
   // parameters change only with the mode off, bar a zero duration byte; writes otherwise are dropped
   assign param_wr = wr_lane & ~enable_reg;
   // a zero into either duration byte is honoured at any time
   assign atr_zero_wr = wr_lane && (wbyte == `SCWT_RST_BYTE)
                        && (hit(paddr, `SCWT_IDX_ATR_HIGH)
                            || hit(paddr, `SCWT_IDX_ATR_LOW));
   // the clear lands on the edge that stores the zero byte, so the counter
   // never counts a further tick on a stale duration
   assign counter_clear = atr_zero_wr;

   // ******************************
   // control register
   // ******************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_reg <= 1'b0;
         type_reg   <= SCWT_T0;
      end else if (wr_lane && hit(paddr, `SCWT_IDX_CTRL)) begin
         // writable while enabled too, else the mode could never be left
         enable_reg <= wbyte[`SCWT_CTRL_ENABLE_BIT];
         type_reg   <= scwt_proto_type'(wbyte[`SCWT_CTRL_TYPE_BIT]);
      end
   end

   // ******************************
   // duration bytes
   // ******************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         atr_high_reg <= `SCWT_RST_BYTE;
         atr_low_reg  <= `SCWT_RST_BYTE;
      end else if (param_wr || atr_zero_wr) begin
         if (hit(paddr, `SCWT_IDX_ATR_HIGH)) begin
            atr_high_reg <= wbyte;
         end else if (hit(paddr, `SCWT_IDX_ATR_LOW)) begin
            atr_low_reg <= wbyte;
         end
      end
   end

   // ******************************
   // wait bytes, banked by protocol type
   // ******************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_high_t0_reg  <= `SCWT_RST_BYTE;
         wait_low_t0_reg   <= `SCWT_RST_WAIT_LOW;
         bwait_high_t1_reg <= `SCWT_RST_BYTE;
         bwait_low_t1_reg  <= `SCWT_RST_WAIT_LOW;
      end else if (param_wr) begin
         if (hit(paddr, `SCWT_IDX_WAIT_HIGH)) begin
            if (type_reg == SCWT_T0) begin
               wait_high_t0_reg <= wbyte;
            end else begin
               bwait_high_t1_reg <= wbyte;
            end
         end else if (hit(paddr, `SCWT_IDX_WAIT_LOW)) begin
            if (type_reg == SCWT_T0) begin
               wait_low_t0_reg <= wbyte;
            end else begin
               bwait_low_t1_reg <= wbyte;
            end
         end
      end
   end

   // ******************************
   // wait-and-guard and second wait
   // ******************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_guard_reg <= `SCWT_RST_BYTE;
         char_wait2_reg <= 5'h00;
      end else if (param_wr) begin
         if (hit(paddr, `SCWT_IDX_WAIT_GUARD)) begin
            wait_guard_reg <= wbyte;
         end else if (hit(paddr, `SCWT_IDX_CHAR_WAIT2)) begin
            // upper three bits are not stored, so they read back zero
            char_wait2_reg <= wbyte[`SCWT_CHAR_WAIT_SECOND_PART_MSB:`SCWT_CHAR_WAIT_SECOND_PART_LSB];
         end
      end
   end

   // ******************************
   // duration counter
   // ******************************
   scwt_atr_counter u_atr (
      .pclk        (pclk),
      .presetn     (presetn),
      .enable      (enable_reg),
      .proto       (type_reg),
      .duration    (join16(atr_high_reg, atr_low_reg)),
      .clear       (counter_clear),
      .ts_detected (ts_detected),
      .etu_tick    (etu_tick),
      .running     (counter_running),
      .expired     (counter_expired)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_reg <= 1'b0;
         exp_reg <= 1'b0;
      end else begin
         // status lags by a cycle; software polls it, so that is harmless
         run_reg <= counter_running;
         exp_reg <= counter_expired;
      end
   end

   // ******************************
   // read data and error, captured at setup
   // ******************************
   always_comb begin
      prdata_next = `SCWT_ZERO_WORD;
      err_next    = 1'b0;
      if (hit(paddr, `SCWT_IDX_CTRL)) begin
         prdata_next[`SCWT_CTRL_ENABLE_BIT] = enable_reg;
         prdata_next[`SCWT_CTRL_TYPE_BIT]   = type_reg;
      end else if (hit(paddr, `SCWT_IDX_STATUS)) begin
         prdata_next[`SCWT_STAT_RUN_BIT] = run_reg;
         prdata_next[`SCWT_STAT_EXP_BIT] = exp_reg;
      end else if (hit(paddr, `SCWT_IDX_ATR_HIGH)) begin
         prdata_next[7:0] = atr_high_reg;
      end else if (hit(paddr, `SCWT_IDX_ATR_LOW)) begin
         prdata_next[7:0] = atr_low_reg;
      end else if (hit(paddr, `SCWT_IDX_WAIT_HIGH)) begin
         // a read shows the bank the counters use under the present type
         prdata_next[7:0] = (type_reg == SCWT_T0) ? wait_high_t0_reg
                                                  : bwait_high_t1_reg;
      end else if (hit(paddr, `SCWT_IDX_WAIT_LOW)) begin
         prdata_next[7:0] = (type_reg == SCWT_T0) ? wait_low_t0_reg
                                                  : bwait_low_t1_reg;
      end else if (hit(paddr, `SCWT_IDX_WAIT_GUARD)) begin
         prdata_next[7:0] = wait_guard_reg;
      end else if (hit(paddr, `SCWT_IDX_CHAR_WAIT2)) begin
         prdata_next[4:0] = char_wait2_reg;
      end else begin
         err_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= `SCWT_ZERO_WORD;
         pslverr <= 1'b0;
      end else if (setup_cycle) begin
         // taken at setup so the answer already stands in the access cycle
         prdata  <= pwrite ? `SCWT_ZERO_WORD : prdata_next;
         pslverr <= err_next;
      end else if (pready) begin
         prdata  <= `SCWT_ZERO_WORD;
         pslverr <= 1'b0;
      end
   end

   // ******************************
   // parameter outputs; t=1 values stay zero under t=0 and vice versa
   // ******************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smartcard_mode_enable   <= 1'b0;
         protocol_type_select    <= SCWT_T0;
         answer_duration_integer <= `SCWT_RST_COUNT;
         char_wait_integer       <= `SCWT_RST_COUNT;
         block_wait_integer      <= `SCWT_RST_COUNT;
         char_wait_first_part    <= 4'h0;
         char_wait_second_part   <= 5'h00;
         block_guard_integer     <= 4'h0;
         answer_duration_running <= 1'b0;
         answer_duration_expired <= 1'b0;
      end else begin
         smartcard_mode_enable   <= enable_reg;
         protocol_type_select    <= type_reg;
         answer_duration_running <= counter_running;
         answer_duration_expired <= counter_expired;
         if (type_reg == SCWT_T0) begin
            answer_duration_integer <= join16(atr_high_reg,
                                              atr_low_reg);
            char_wait_integer <= join16(wait_high_t0_reg,
                                        wait_low_t0_reg);
            block_wait_integer    <= `SCWT_RST_COUNT;
            char_wait_first_part  <= 4'h0;
            char_wait_second_part <= 5'h00;
            block_guard_integer   <= 4'h0;
         end else begin
            answer_duration_integer <= `SCWT_RST_COUNT;
            char_wait_integer       <= `SCWT_RST_COUNT;
            block_wait_integer <= join16(bwait_high_t1_reg,
                                         bwait_low_t1_reg);
            char_wait_first_part <=
               wait_guard_reg[`SCWT_CHAR_WAIT_FIRST_PART_MSB:`SCWT_CHAR_WAIT_FIRST_PART_LSB];
            char_wait_second_part <= char_wait2_reg;
            block_guard_integer <=
               wait_guard_reg[`SCWT_BGI_MSB:`SCWT_BGI_LSB];
         end
      end
   end
endmodule : scwt_params

// File: test/scwt_params_sva.sv
// assertion checker for the smart-card wait parameter bank
`timescale 1ns/1ns
module scwt_params_sva (
   input wire logic                      pclk,
   input wire logic                      presetn,
   input wire logic                      psel,
   input wire logic                      penable,
   input wire logic                      pwrite,
   input wire logic [7:0]                paddr,
   input wire logic                      ts_detected,
   input wire logic [31:0]               prdata,
   input wire logic                      pready,
   input wire logic                      pslverr,
   input wire scwt_pkg::scwt_proto_type  protocol_type_select,
   input wire scwt_pkg::scwt_word16_type answer_duration_integer,
   input wire scwt_pkg::scwt_word16_type char_wait_integer,
   input wire scwt_pkg::scwt_word16_type block_wait_integer,
   input wire logic [3:0]                char_wait_first_part,
   input wire logic [4:0]                char_wait_second_part,
   input wire logic [3:0]                block_guard_integer,
   input wire logic                      answer_duration_running,
   input wire logic                      answer_duration_expired
);
   import scwt_pkg::*;
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_next: assert property (
      psel && !penable |=> pready) else $error("no ready after setup");
   chk_ready_one: assert property (
      pready |-> psel && penable ##1 !pready)
      else $error("ready outside single access cycle");
   chk_rsvd_zero: assert property (
      pready && !pwrite && paddr == 8'hFC |-> prdata[31:5] == 27'h0)
      else $error("reserved bits of 3Fh read nonzero");
   chk_t0_fields: assert property (
      protocol_type_select == SCWT_T0 && $stable(protocol_type_select)
      |-> block_wait_integer == 16'h0000 && char_wait_first_part == 4'h0
      && block_guard_integer == 4'h0 && char_wait_second_part == 5'h00)
      else $error("t1 fields live under t0");
   chk_t1_fields: assert property (
      protocol_type_select == SCWT_T1 && $stable(protocol_type_select)
      |-> answer_duration_integer == 16'h0000
      && char_wait_integer == 16'h0000) else $error("t0 fields live");
   chk_zero_idle: assert property (
      answer_duration_integer == 16'h0000 [*3] |-> !answer_duration_running)
      else $error("counter runs with zero duration");
   chk_start_ts: assert property (
      $rose(answer_duration_running)
      |-> $past(ts_detected) || $past(ts_detected, 2))
      else $error("counter started without ts");
   chk_expire_run: assert property (
      $rose(answer_duration_expired) |-> $past(answer_duration_running))
      else $error("expired without running");
   cover property (pslverr);
   cover property ($rose(answer_duration_expired));
   cover property (pready && protocol_type_select == SCWT_T1);
endmodule : scwt_params_sva

bind scwt_params scwt_params_sva u_sva (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .ts_detected,
   .prdata, .pready, .pslverr, .protocol_type_select,
   .answer_duration_integer, .char_wait_integer, .block_wait_integer,
   .char_wait_first_part, .char_wait_second_part, .block_guard_integer,
   .answer_duration_running, .answer_duration_expired);

// File: test/scwt_card_model.sv
// smart card stand-in: etu ticks and the ts character at answer-to-reset
`timescale 1ns/1ns
module scwt_card_model #(
   parameter int ETU_CYCLES = 3
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic start_atr,
   output logic      ts_detected,
   output logic      etu_tick
);
   int   div_reg;
   int   bits_reg;
   logic in_ts_reg;
   // ticks run free, as the card clock does while powered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg  <= 0;
         etu_tick <= 1'b0;
      end else begin
         div_reg  <= (div_reg == ETU_CYCLES - 1) ? 0 : div_reg + 1;
         etu_tick <= (div_reg == ETU_CYCLES - 1);
      end
   end
   // ts is flagged only once its full ten etus are over
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_ts_reg   <= 1'b0;
         bits_reg    <= 0;
         ts_detected <= 1'b0;
      end else begin
         ts_detected <= 1'b0;
         if (start_atr) begin
            in_ts_reg <= 1'b1;
            bits_reg  <= 0;
         end else if (in_ts_reg && etu_tick) begin
            bits_reg <= bits_reg + 1;
            if (bits_reg == 9) begin
               in_ts_reg   <= 1'b0;
               ts_detected <= 1'b1;
            end
         end
      end
   end
endmodule : scwt_card_model

// File: test/scwt_params_tb.sv
// self-checking bench for the smart-card wait parameter bank
`timescale 1ns/1ns
module scwt_params_tb;
   import scwt_pkg::*;
   logic            pclk = 1'b0;
   logic            presetn = 1'b0;
   logic            psel = 1'b0;
   logic            penable = 1'b0;
   logic            pwrite = 1'b0;
   logic [7:0]      paddr = 8'h00;
   logic [31:0]     pwdata = 32'h0;
   logic [3:0]      pstrb = 4'hF;
   logic            start_atr = 1'b0;
   logic            ts_detected;
   logic            etu_tick;
   logic [31:0]     prdata;
   logic            pready;
   logic            pslverr;
   logic            smartcard_mode_enable;
   scwt_proto_type  protocol_type_select;
   scwt_word16_type answer_duration_integer;
   scwt_word16_type char_wait_integer;
   scwt_word16_type block_wait_integer;
   logic [3:0]      char_wait_first_part;
   logic [4:0]      char_wait_second_part;
   logic [3:0]      block_guard_integer;
   logic            answer_duration_running;
   logic            answer_duration_expired;
   int              fail_count = 0;
   int              comparisons = 0;
   logic [31:0]     rd_data;
   logic            rd_err;
   scwt_byte_type   b [6];
   int              n;
   int              run_cycles = 0;

   scwt_params DUT (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .ts_detected, .etu_tick, .prdata, .pready, .pslverr,
      .smartcard_mode_enable, .protocol_type_select,
      .answer_duration_integer, .char_wait_integer, .block_wait_integer,
      .char_wait_first_part, .char_wait_second_part, .block_guard_integer,
      .answer_duration_running, .answer_duration_expired
   );
   scwt_card_model card (
      .pclk, .presetn, .start_atr, .ts_detected, .etu_tick
   );

   always #2 pclk = ~pclk;

   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) fail_count++;
      rd_data = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input logic err);
      apb(a, 1'b0, 32'h0);
      check(rd_data, exp);
      check({31'h0, rd_err}, {31'h0, err});
   endtask : rd

   // outputs trail a write by up to two cycles
   task automatic settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask : settle

   function automatic logic [31:0] exp_byte(input logic [7:0] a,
                                            input scwt_byte_type v);
      return (a == 8'hFC) ? {27'h0, v[4:0]} : {24'h0, v};
   endfunction : exp_byte

   task automatic complete_run();
      if (fail_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   // ****************************************
   // sequence
   // ****************************************
   initial begin
      #100000;
      fail_count++;
      complete_run();
   end

   initial begin
      void'($urandom(32'h9282));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd(8'hE8 + 8'(4 * i), (i == 3) ? 32'h38 : 32'h0, 1'b0);
      end
      settle();
      check(32'(char_wait_integer), 32'h0038);
      for (int r = 0; r < 4; r++) begin
         // bytes are never zero, so no wait integer is programmed to zero
         for (int i = 0; i < 6; i++) begin
            b[i] = 8'($urandom_range(1, 254));
         end
         wr(8'hC0, 32'h0);
         for (int i = 0; i < 6; i++) wr(8'hE8 + 8'(4 * i), {24'h0, b[i]});
         settle();
         check(32'(answer_duration_integer), {16'h0, b[0], b[1]});
         check(32'(char_wait_integer), {16'h0, b[2], b[3]});
         check(32'(block_wait_integer), 32'h0);
         check({31'h0, protocol_type_select}, 32'h0);
         wr(8'hC0, 32'h2);
         wr(8'hF0, {24'h0, ~b[2]});
         wr(8'hF4, {24'h0, ~b[3]});
         settle();
         check(32'(block_wait_integer), {16'h0, ~b[2], ~b[3]});
         check({31'h0, protocol_type_select}, 32'h1);
         check({24'h0, char_wait_first_part, block_guard_integer},
               {24'h0, b[4]});
         check({27'h0, char_wait_second_part}, {27'h0, b[5][4:0]});
         check({answer_duration_integer, char_wait_integer}, 32'h0);
         rd(8'hF0, {24'h0, ~b[2]}, 1'b0);
         rd(8'hFC, exp_byte(8'hFC, b[5]), 1'b0);
         wr(8'hFC, 32'hFF);
         rd(8'hFC, 32'h1F, 1'b0);
         wr(8'hC0, 32'h0);
         rd(8'hF4, {24'h0, b[3]}, 1'b0);
      end
      // refused accesses: strobe off, unmapped, misaligned
      pstrb <= 4'hE;
      wr(8'hE8, 32'h5A);
      pstrb <= 4'hF;
      rd(8'hE8, {24'h0, b[0]}, 1'b0);
      rd(8'h80, 32'h0, 1'b1);
      rd(8'hEA, 32'h0, 1'b1);
      // duration counter: writes dropped while enabled, then a full run
      wr(8'hE8, 32'h0);
      wr(8'hEC, 32'h3);
      wr(8'hC0, 32'h1);
      wr(8'hF0, 32'h77);
      wr(8'hE8, 32'h44);
      rd(8'hF0, {24'h0, b[2]}, 1'b0);
      rd(8'hE8, 32'h0, 1'b0);
      settle();
      check({31'h0, answer_duration_running}, 32'h0);
      check({31'h0, smartcard_mode_enable}, 32'h1);
      @(posedge pclk);
      start_atr <= 1'b1;
      @(posedge pclk);
      start_atr <= 1'b0;
      n = 0;
      while (answer_duration_expired !== 1'b1 && n < 400) begin
         @(posedge pclk);
         n++;
         if (answer_duration_running === 1'b1) run_cycles++;
      end
      check({31'h0, n >= 33 && n <= 50}, 32'h1);
      // three etus of count; the first tick may come one phase early
      check({31'h0, run_cycles >= 7 && run_cycles <= 9}, 32'h1);
      rd(8'hC4, 32'h2, 1'b0);
      wr(8'hEC, 32'h0);
      settle();
      check({30'h0, answer_duration_running, answer_duration_expired},
            32'h0);
      rd(8'hEC, 32'h0, 1'b0);
      complete_run();
   end
endmodule : scwt_params_tb
